// ==== shared/adc_cfg_pkg.sv ====
// constants and carrier types for the converter configuration bank
package adc_cfg_pkg;
  // ----------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [4:0] LAST_BIT_IDX = 5'h17;  // 24 bits per word
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SOFT_RESET = 8'h00;
  localparam logic [7:0] REG_POWER_MGMT = 8'h0f;
  localparam logic [7:0] REG_DRIVE = 8'h11;
  localparam logic [7:0] REG_TERM = 8'h12;
  localparam logic [7:0] REG_POLARITY = 8'h24;
  localparam logic [7:0] REG_PATTERN = 8'h25;
  localparam logic [7:0] REG_WORD1 = 8'h26;
  localparam logic [7:0] REG_WORD2 = 8'h27;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SOFT_RESET_BIT = 0;
  localparam int QUAD_SLEEP_LSB = 0;
  localparam int DUAL_SLEEP_LSB = 4;
  localparam int SINGLE_SLEEP_BIT = 6;
  localparam int SLEEP_BIT = 8;
  localparam int POWER_DOWN_BIT = 9;
  localparam int PIN_FN_LSB = 10;
  localparam int QUAD_POL_LSB = 0;
  localparam int DUAL_POL_LSB = 4;
  localparam int SINGLE_POL_BIT = 6;
  localparam int PAT_CONST_BIT = 4;
  localparam int PAT_TOGGLE_BIT = 5;
  localparam int PAT_RAMP_BIT = 6;
  // writable bits of each register
  localparam logic [15:0] PM_MASK = 16'h0f7f;
  localparam logic [15:0] DRIVE_MASK = 16'h0777;
  localparam logic [15:0] TERM_MASK = 16'h4777;
  localparam logic [15:0] POL_MASK = 16'h007f;
  localparam logic [15:0] PAT_MASK = 16'h0070;
  // ----------------------------------------------------------------
  // reset values and power-down pin functions
  // ----------------------------------------------------------------
  localparam logic [15:0] PM_RESET = 16'h0000;
  localparam logic [15:0] DRIVE_RESET = 16'h0000;
  localparam logic [15:0] TERM_RESET = 16'h0000;
  localparam logic [15:0] POL_RESET = 16'h0000;
  localparam logic [15:0] PAT_RESET = 16'h0000;
  localparam logic [15:0] WORD1_RESET = 16'h0000;
  localparam logic [15:0] WORD2_RESET = 16'h0000;
  localparam logic [1:0] PIN_FN_POWER_DOWN = 2'h0;
  localparam logic [1:0] PIN_FN_SLEEP = 2'h1;

  // all register contents, travelling together
  typedef struct packed {
    logic [15:0] power_mgmt;
    logic [15:0] drive;
    logic [15:0] term;
    logic [15:0] polarity;
    logic [15:0] pattern;
    logic [15:0] first_pattern_word;
    logic [15:0] second_pattern_word;
  } regs_s;
endpackage

// ==== src/adc_cfg_regs.sv ====
// serial configuration port and lower register bank of the converter
// Operation
// - per-channel sleep bits for quad, dual, single
// - bits 11:10 pick power-down pin function
// - quad channels swap input polarity, bits 3:0
// - dual bits 5:4, single bit 6 swap
// - three prioritised pattern enables (ramp, toggle, constant), none means data
// - first word: constant code, toggles with second
// - software reset restores defaults, bit self-clears
// - commit a word every 24th rising clock
// - word is 8-bit address then 16-bit data
`timescale 1ns/1ns
module adc_cfg_regs
  import adc_cfg_pkg::*;
#(
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic hardware_reset_low,
  // serial configuration port pins
  input wire logic serial_clock,
  input wire logic serial_config_data,
  input wire logic serial_select_low,
  // power-down pin
  input wire logic power_down_pin,
  // conversion data path
  input wire logic sample_valid,
  input wire logic [DW-1:0] conv_data,
  // configuration and state
  output regs_s cfg_r,
  output logic soft_reset_r,
  output logic power_down_r,
  output logic sleep_r,
  // pattern or sample output
  output logic [DW-1:0] data_out_r,
  output logic valid_out_r
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s1, sclk_s2, sclk_s3;
  logic sel_s1, sel_s2;
  logic dat_s1, dat_s2;
  logic pin_s1, pin_s2;

  // select and data two deep, level with sclk_s2 where the edge is taken, keeps them aligned
  always_ff @(posedge clk_sys or negedge hardware_reset_low) begin
    if (!hardware_reset_low) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      sclk_s1 <= serial_clock;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sel_s1 <= serial_select_low;
      sel_s2 <= sel_s1;
      dat_s1 <= serial_config_data;
      dat_s2 <= dat_s1;
      pin_s1 <= power_down_pin;
      pin_s2 <= pin_s1;
    end
  end

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  logic sclk_rise;
  logic [23:0] shift_r;
  logic [4:0] bit_cnt_r;
  logic [23:0] word_nxt;
  logic commit;
  logic [ADDR_W-1:0] word_addr;
  logic [DATA_W-1:0] word_data;

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign word_nxt = {shift_r[22:0], dat_s2};
  // word completes on the 24th rising edge
  assign commit = sclk_rise & ~sel_s2 & (bit_cnt_r == LAST_BIT_IDX);
  assign word_addr = word_nxt[23:16];
  assign word_data = word_nxt[15:0];

  // sample data while selected; partial words die at deselect
  always_ff @(posedge clk_sys or negedge hardware_reset_low) begin
    if (!hardware_reset_low) begin
      shift_r <= '0;
      bit_cnt_r <= '0;
    end else if (sel_s2) begin
      bit_cnt_r <= '0;
    end else if (sclk_rise) begin
      shift_r <= word_nxt;
      bit_cnt_r <= commit ? 5'h00 : bit_cnt_r + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  // one-cycle software reset, clears itself
  always_ff @(posedge clk_sys or negedge hardware_reset_low) begin
    if (!hardware_reset_low) begin
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= commit && word_addr == REG_SOFT_RESET && word_data[SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge hardware_reset_low) begin
    if (!hardware_reset_low) begin
      cfg_r.power_mgmt <= PM_RESET;
      cfg_r.drive <= DRIVE_RESET;
      cfg_r.term <= TERM_RESET;
      cfg_r.polarity <= POL_RESET;
      cfg_r.pattern <= PAT_RESET;
      cfg_r.first_pattern_word <= WORD1_RESET;
      cfg_r.second_pattern_word <= WORD2_RESET;
    end else if (soft_reset_r) begin
      cfg_r.power_mgmt <= PM_RESET;
      cfg_r.drive <= DRIVE_RESET;
      cfg_r.term <= TERM_RESET;
      cfg_r.polarity <= POL_RESET;
      cfg_r.pattern <= PAT_RESET;
      cfg_r.first_pattern_word <= WORD1_RESET;
      cfg_r.second_pattern_word <= WORD2_RESET;
    end else if (commit) begin
      // unmapped addresses are dropped silently
      case (word_addr)
        REG_POWER_MGMT: cfg_r.power_mgmt <= word_data & PM_MASK;
        REG_DRIVE: cfg_r.drive <= word_data & DRIVE_MASK;
        REG_TERM: cfg_r.term <= word_data & TERM_MASK;
        REG_POLARITY: cfg_r.polarity <= word_data & POL_MASK;
        REG_PATTERN: cfg_r.pattern <= word_data & PAT_MASK;
        REG_WORD1: cfg_r.first_pattern_word <= word_data;
        REG_WORD2: cfg_r.second_pattern_word <= word_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  logic [1:0] pin_fn;
  assign pin_fn = cfg_r.power_mgmt[PIN_FN_LSB+:2];

  // pin acts by its function; bit cycling is an alternative
  always_ff @(posedge clk_sys or negedge hardware_reset_low) begin
    if (!hardware_reset_low) begin
      power_down_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      power_down_r <= cfg_r.power_mgmt[POWER_DOWN_BIT] |
                      (pin_s2 & (pin_fn == PIN_FN_POWER_DOWN));
      sleep_r <= cfg_r.power_mgmt[SLEEP_BIT] | (pin_s2 & (pin_fn == PIN_FN_SLEEP));
    end
  end

  // ----------------------------------------------------------------
  // pattern generator
  // ----------------------------------------------------------------
  pattern_gen #(.DW(DW)) u_pattern (
    .clk_sys(clk_sys),
    .hardware_reset_low(hardware_reset_low),
    .sample_valid(sample_valid),
    .conv_data(conv_data),
    .pattern(cfg_r.pattern),
    .word1(cfg_r.first_pattern_word[DW-1:0]),
    .word2(cfg_r.second_pattern_word[DW-1:0]),
    .data_out_r(data_out_r),
    .valid_out_r(valid_out_r)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_only_on_commit: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    !$past(commit) && !$past(soft_reset_r) |-> cfg_r == $past(cfg_r))
    else $error("register changed without a whole word");
  a_sleep_write: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    commit && word_addr == REG_POWER_MGMT
    |=> cfg_r.power_mgmt[6:0] == $past(word_data[6:0]))
    else $error("sleep bits not stored");
  a_pin_powerdown: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    pin_s2 && pin_fn == PIN_FN_POWER_DOWN |=> power_down_r)
    else $error("pin did not power down");
  a_polarity_write: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    commit && word_addr == REG_POLARITY |=> cfg_r.polarity == $past(word_data & POL_MASK))
    else $error("polarity bits not stored");
  a_addr_order: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    commit && word_addr == REG_WORD1 |=> cfg_r.first_pattern_word == $past(shift_r[14:0])*2
      + $past(dat_s2))
    else $error("data bits misplaced");
  a_soft_reset: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    soft_reset_r |=> cfg_r == '0 && !soft_reset_r)
    else $error("software reset incomplete");
  a_reset_trigger: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    commit && word_addr == REG_SOFT_RESET && word_data[0] |=> soft_reset_r ##1 !soft_reset_r)
    else $error("software reset not pulsed");
endmodule

// ==== src/pattern_gen.sv ====
// test pattern generator and output data selector
`timescale 1ns/1ns
module pattern_gen
  import adc_cfg_pkg::*;
#(
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic hardware_reset_low,
  // conversion samples
  input wire logic sample_valid,
  input wire logic [DW-1:0] conv_data,
  // settings
  input wire logic [15:0] pattern,
  input wire logic [DW-1:0] word1,
  input wire logic [DW-1:0] word2,
  // selected output
  output logic [DW-1:0] data_out_r,
  output logic valid_out_r
);
  logic [DW-1:0] ramp_r;
  logic phase_r;
  logic ramp_on;
  logic toggle_on;
  logic const_on;

  // ramp wins over toggle, toggle over constant, if software sets several
  assign ramp_on = pattern[PAT_RAMP_BIT];
  assign toggle_on = pattern[PAT_TOGGLE_BIT] & ~ramp_on;
  assign const_on = pattern[PAT_CONST_BIT] & ~ramp_on & ~pattern[PAT_TOGGLE_BIT];

  always_ff @(posedge clk_sys or negedge hardware_reset_low) begin
    if (!hardware_reset_low) begin
      ramp_r <= '0;
    end else if (!ramp_on) begin
      ramp_r <= '0;
    end else if (sample_valid) begin
      ramp_r <= ramp_r + 1'b1;  // wraps at full scale by width
    end
  end

  always_ff @(posedge clk_sys or negedge hardware_reset_low) begin
    if (!hardware_reset_low) begin
      phase_r <= 1'b0;
    end else if (!toggle_on) begin
      phase_r <= 1'b0;
    end else if (sample_valid) begin
      phase_r <= ~phase_r;
    end
  end

  // output mux, normal data when no pattern
  always_ff @(posedge clk_sys or negedge hardware_reset_low) begin
    if (!hardware_reset_low) begin
      data_out_r <= '0;
      valid_out_r <= 1'b0;
    end else begin
      valid_out_r <= sample_valid;
      if (sample_valid) begin
        if (ramp_on) data_out_r <= ramp_r;
        else if (toggle_on) data_out_r <= phase_r ? word2 : word1;
        else if (const_on) data_out_r <= word1;
        else data_out_r <= conv_data;
      end
    end
  end

  a_pass_through: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    sample_valid && pattern[6:4] == 3'h0 |=> data_out_r == $past(conv_data))
    else $error("normal data not passed through");
  a_constant_code: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    sample_valid && const_on |=> data_out_r == $past(word1))
    else $error("constant pattern wrong");
  a_toggle_alt: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    sample_valid && toggle_on && !phase_r ##1 sample_valid && toggle_on
    |=> data_out_r == $past(word2))
    else $error("toggle did not alternate");
  a_ramp_step: assert property (@(posedge clk_sys) disable iff (!hardware_reset_low)
    sample_valid && ramp_on ##1 sample_valid && ramp_on
    |=> data_out_r == DW'($past(data_out_r) + 1'b1))
    else $error("ramp did not step by one");
endmodule

// ==== verification/host_model.sv ====
// host controller model driving the three-wire serial configuration port
`timescale 1ns/1ns
module host_model (
  // system clock used to pace the serial lines
  input wire logic clk_sys,
  // serial port lines
  output logic serial_clock,
  output logic serial_config_data,
  output logic serial_select_low
);
  // serial clock stands low and select high outside frames
  initial begin
    serial_clock = 1'b0;
    serial_config_data = 1'b0;
    serial_select_low = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // 4 clocks of margin, the device oversamples by 3
  task automatic select(input logic on);
    tick(4);
    serial_select_low <= ~on;
    // released data line is not left showing the last bit
    if (!on) serial_config_data <= ~serial_config_data;
    tick(4);
  endtask

  // data stable around each rising edge
  task automatic shift_bit(input logic b);
    serial_config_data <= b;
    tick(4);
    serial_clock <= 1'b1;
    tick(4);
    serial_clock <= 1'b0;
  endtask

  // address byte then data, msb first
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) shift_bit(w[i]);
  endtask
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the configuration register bank
`timescale 1ns/1ns
module testbench;
  import adc_cfg_pkg::*;
  logic clk_sys = 1'b0;
  logic hardware_reset_low = 1'b0;
  logic power_down_pin = 1'b0;
  logic sample_valid = 1'b0;
  logic [15:0] conv_data = 16'h0000;
  wire serial_clock;
  wire serial_config_data;
  wire serial_select_low;
  regs_s cfg_r;
  logic [111:0] exp_r = '0;
  logic soft_reset_r, power_down_r, sleep_r, valid_out_r;
  logic [15:0] data_out_r;
  logic [7:0] addr_t [7] = '{8'h0f, 8'h11, 8'h12, 8'h24, 8'h25, 8'h26, 8'h27};
  logic [15:0] mask_t [7] = '{PM_MASK, DRIVE_MASK, TERM_MASK, POL_MASK, PAT_MASK,
    16'hffff, 16'hffff};
  int n_fail = 0;
  int comparisons = 0;

  // 50 ns period
  always #25 clk_sys = ~clk_sys;

  host_model u_host (.clk_sys(clk_sys), .serial_clock(serial_clock),
    .serial_config_data(serial_config_data), .serial_select_low(serial_select_low));

  adc_cfg_regs #(.DW(16)) u_dut (.clk_sys(clk_sys), .hardware_reset_low(hardware_reset_low),
    .serial_clock(serial_clock), .serial_config_data(serial_config_data),
    .serial_select_low(serial_select_low), .power_down_pin(power_down_pin),
    .sample_valid(sample_valid), .conv_data(conv_data), .cfg_r(cfg_r),
    .soft_reset_r(soft_reset_r), .power_down_r(power_down_r), .sleep_r(sleep_r),
    .data_out_r(data_out_r), .valid_out_r(valid_out_r));

  task automatic give_verdict();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [111:0] got, input logic [111:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one whole word in its own frame, then time for the commit
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.select(1'b1);
    u_host.send_word({a, d});
    u_host.select(1'b0);
    u_host.tick(8);
  endtask

  // one sample pulse, output checked the cycle after it is taken
  task automatic smp(input logic [15:0] exp);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    conv_data <= 16'h5a5a;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    #1;
    chk({valid_out_r, data_out_r}, {1'b1, exp});
  endtask

  // hang guard, roughly fourteen times the expected run
  initial begin
    #3ms;
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    hardware_reset_low <= 1'b1;
    u_host.tick(4);
    chk(cfg_r, exp_r);
    // every register written with all ones, reserved bits stay clear
    for (int i = 0; i < 7; i++) begin
      wr(addr_t[i], 16'hffff);
      exp_r[111-16*i -: 16] = mask_t[i];
      chk(cfg_r, exp_r);
    end
    wr(8'h13, 16'h0000);
    chk(cfg_r, exp_r);
    wr(8'h24, 16'h0000);
    exp_r[63:48] = 16'h0000;
    chk(cfg_r, exp_r);
    // partial word is dropped at deselect
    u_host.select(1'b1);
    for (int i = 0; i < 12; i++) u_host.shift_bit(1'b0);
    u_host.select(1'b0);
    u_host.tick(8);
    chk(cfg_r, exp_r);
    // two words in one frame
    u_host.select(1'b1);
    u_host.send_word({REG_WORD1, 16'h1234});
    u_host.send_word({REG_WORD2, 16'habcd});
    u_host.select(1'b0);
    u_host.tick(8);
    exp_r[31:0] = 32'h1234abcd;
    chk(cfg_r, exp_r);
    // pattern modes: none, constant, toggle, ramp
    wr(REG_PATTERN, 16'h0000);
    smp(16'h5a5a);
    wr(REG_PATTERN, 16'h0010);
    smp(16'h1234);
    smp(16'h1234);
    wr(REG_PATTERN, 16'h0020);
    smp(16'h1234);
    smp(16'habcd);
    smp(16'h1234);
    wr(REG_PATTERN, 16'h0040);
    for (int i = 0; i < 3; i++) smp(16'(i));
    // power-down bit cycling
    wr(REG_POWER_MGMT, 16'h0200);
    chk(power_down_r, 1'b1);
    wr(REG_POWER_MGMT, 16'h0000);
    chk(power_down_r, 1'b0);
    // pin defaults to power-down, then reassigned to sleep
    @(posedge clk_sys);
    power_down_pin <= 1'b1;
    u_host.tick(6);
    chk({power_down_r, sleep_r}, 2'b10);
    wr(REG_POWER_MGMT, 16'h0400);
    chk({power_down_r, sleep_r}, 2'b01);
    power_down_pin <= 1'b0;
    // software reset restores defaults and clears itself
    wr(REG_SOFT_RESET, 16'h0001);
    chk(cfg_r, '0);
    chk(soft_reset_r, 1'b0);
    give_verdict();
  end
endmodule
